/* dv/event_router_checker_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module event_router_checker (
	input wire logic mclk,
	input wire logic reset,
	input wire event_router_pkg::evt_cmd_t coreCmd,
	input wire event_router_pkg::ext_src_t extSrc,
	input wire logic [63:0] pending_r,
	input wire logic [15:0] chanActive_r,
	input wire logic [1:0] firstCoreHostLines_r,
	input wire logic [7:0] exportedHosts_r
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	sequence coreSet; coreCmd.set && coreCmd.evt inside {[16:31]}; endsequence
	// Seven samples cover the sync and agree stages
	a_core_set:
		assert property (coreSet |=> pending_r[$past(coreCmd.evt)]) else $error("s");
	a_spare_quiet: assert property (!pending_r[50:48]) else $error("q");
	a_suspend_in:
		assert property (extSrc.suspend [*7] |-> pending_r[58]) else $error("u");
	a_trip_or:
		assert property ((extSrc.pwmATrip | extSrc.pwmBTrip) [*7] |-> pending_r[56])
		else $error("t");
	a_pend_hold:
		assert property ($fell(pending_r[20]) |->
			$past(coreCmd.clr && coreCmd.evt == 6'd20)) else $error("h");
	a_chan_cause:
		assert property (|chanActive_r |-> $past(|pending_r)) else $error("c");
	a_core_host:
		assert property (|firstCoreHostLines_r |-> $past(|chanActive_r)) else $error("k");
	a_export_host:
		assert property (|exportedHosts_r |-> $past(|chanActive_r)) else $error("x");
endmodule // event_router_checker
bind subsystem_event_router event_router_checker chk(.mclk, .reset, .coreCmd,
	.extSrc, .pending_r, .chanActive_r, .firstCoreHostLines_r, .exportedHosts_r);
`default_nettype wire

/* dv/periph_model.sv */
`timescale 1ns/1ns
`default_nettype none
module periph_model (
	input wire logic mclk,
	input wire logic [5:0] req,
	output var event_router_pkg::ext_src_t src
);
	always_ff @(posedge mclk) src <= req;
endmodule // periph_model
`default_nettype wire

/* dv/subsystem_event_router_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin numErrors++; \
	$display("ERROR %0t %h %h", $time, a, b); end end
module subsystem_event_router_bench;
	logic mclk = 0, reset = 1;
	logic [5:0] req = 0;
	logic [15:0] moduleEvents = 0;
	logic [63:0] enable = '1, chanToHost = '1, pending_r;
	logic [255:0] evtToChan = 0;
	wire [9:0] h;
	logic [15:0] extEv = 0, chanAct;
	logic [31:0] outData = 0, gpPins = 0, coreOut, coreIn;
	logic outWr = 0;
	logic [1:0] ioMode = 0;
	logic [25:0] expR;
	int pend[$];
	event_router_pkg::ext_src_t extSrc;
	event_router_pkg::evt_cmd_t coreCmd = 0;
	int numErrors = 0, numChecks = 0, cyc = 0, ev, c;
	int ext[6] = '{56, 56, 32, 52, 51, 58};
	periph_model peri(.mclk, .req, .src(extSrc));
	subsystem_event_router dut(.mclk, .reset, .moduleEvents,
		.extEvents(extEv), .extSrc, .coreCmd, .enable, .evtToChan,
		.chanToHost, .outWriteData(outData), .outWrite(outWr), .ioMode,
		.generalInputPins(gpPins), .coreGeneralOutput_r(coreOut),
		.coreInputEvent_r(coreIn), .pending_r, .chanActive_r(chanAct),
		.firstCoreHostLines_r(h[1:0]), .exportedHosts_r(h[9:2]));
	always #10 mclk = ~mclk;
	always @(posedge mclk) if (++cyc > 1000) begin numErrors++; endSim; end
	task tick(int n); repeat (n) @(posedge mclk); #1; endtask
	// Model of pending core events, fed by the same calls as the design
	task send(int e, bit s);
		coreCmd = {6'(e), s, !s};
		if (s && e >= 16 && e < 32)
			pend.push_back(e);
		for (int k = pend.size() - 1; k >= 0; k--)
			if (!s && pend[k] == e)
				pend.delete(k);
		tick(1);
		coreCmd = 0;
	endtask
	function automatic logic [25:0] expRoute();
		logic [25:0] r;
		int ch;
		r = 0;
		foreach (pend[k])
			if (enable[pend[k]]) begin
				ch = evtToChan[pend[k]*4 +: 4];
				r[10 + ch] = 1'b1;
				if (chanToHost[ch*4 +: 4] < 10)
					r[chanToHost[ch*4 +: 4]] = 1'b1;
			end
		return r;
	endfunction
	task endSim;
		if (numErrors == 0 && numChecks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(32'he90e));
		tick(20);
		reset = 0;
		outData = $urandom;
		outWr = 1;
		tick(1);
		outWr = 0;
		`CHK(coreOut, outData)
		for (int m = 0; m < 2; m++) begin
			ioMode = 2'(m);
			gpPins = $urandom;
			tick(8);
			`CHK(coreIn, {2'b00, gpPins[29:0]})
		end
		for (int i = 0; i < 4; i++) begin
			c = $urandom % 16;
			extEv = 16'h1 << c;
			tick(8);
			`CHK(pending_r[32 + c], 1'b1)
			extEv = 0;
			tick(8);
			send(32 + c, 0);
			`CHK(pending_r[32 + c], 1'b0)
		end
		for (int i = 0; i < 22; i++) begin
			{req, moduleEvents} = 22'h1 << i;
			ev = i < 16 ? i : ext[i - 16];
			tick(8);
			`CHK(pending_r[ev], 1'b1)
			{req, moduleEvents} = 0;
			tick(8);
			send(ev, 0);
			`CHK(pending_r[ev], 1'b0)
		end
		for (int i = 0; i < 20; i++) begin
			ev = i < 10 ? 20 : $urandom % 64;
			c = i % 9 ? $urandom % 16 : 0;
			evtToChan = {64{4'(c)}};
			chanToHost = '1;
			chanToHost[c*4 +: 4] = 4'(i % 10);
			send(ev, 1);
			tick(2);
			expR = expRoute();
			`CHK(h, expR[9:0])
			`CHK(chanAct, expR[25:10])
			send(ev, 0);
			tick(2);
		end
		enable[20] = 0;
		send(20, 1);
		tick(2);
		expR = expRoute();
		`CHK(pending_r[20], 1'b1)
		`CHK({chanAct, h}, expR)
		send(20, 0);
		enable = '1;
		endSim;
	end
endmodule // subsystem_event_router_bench
`default_nettype wire

/* rtl/subsystem_event_router.sv */
`timescale 1ns/1ns
`default_nettype none
`include "event_router_map.svh"
// Overview of operation
// - 64 events to 16 channels to 10 hosts
// - Hosts 0-1 to cores, 2-9 exported
// - Events 32-63 external, 16-31 core-written
// - Events 0-15 from internal modules
// - Core output/input registers, direct mode default
// - Emulation suspend arrives as event 58
// - Two PWM trip interrupts ORed, event 56
// - Serial interrupts on 51, 32, 52 only
module subsystem_event_router #(
	parameter int NEV = `ER_NUM_EVENTS,
	parameter int NCH = `ER_NUM_CHANNELS,
	parameter int NHO = `ER_NUM_HOSTS
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [15:0] moduleEvents,
	input wire logic [15:0] extEvents,
	input wire event_router_pkg::ext_src_t extSrc,
	input wire event_router_pkg::evt_cmd_t coreCmd,
	input wire logic [NEV-1:0] enable,
	input wire logic [NEV*4-1:0] evtToChan,
	input wire logic [NCH*4-1:0] chanToHost,
	input wire logic [31:0] outWriteData,
	input wire logic outWrite,
	input wire logic [1:0] ioMode,
	input wire logic [31:0] generalInputPins,
	output logic [31:0] coreGeneralOutput_r,
	output logic [31:0] coreInputEvent_r,
	output logic [NEV-1:0] pending_r,
	output logic [NCH-1:0] chanActive_r,
	output logic [1:0] firstCoreHostLines_r,
	output logic [NHO-3:0] exportedHosts_r
);
	localparam int SS = `ER_SYNC_STAGES;
	localparam int NASYNC = 21;
	localparam int NPIN = 32;

	// Asynchronous sources, one synchroniser each:
	// [20] suspend, [19:18] serial B/A, [17] trip, [16] serial C,
	// [15:0] external lines for events 32-47
	logic [NASYNC-1:0] rawIn;
	logic [SS-1:0] syncPipe [0:NASYNC-1];
	logic [NASYNC-1:0] stable;
	logic [NASYNC-1:0] cleanIn_r;

	// General input pins have their own synchronisers
	logic [SS-1:0] pinPipe [0:NPIN-1];
	logic [NPIN-1:0] pinStable;
	logic [NPIN-1:0] gpIn_r;

	logic tripMerged;
	logic coreSetOk;
	logic [NEV-1:0] modLevel;
	logic [NEV-1:0] extLevel;
	logic [NEV-1:0] coreLevel;
	logic [NEV-1:0] evtLevel;
	logic [NEV-1:0] clrMask;
	logic [NEV-1:0] setNxt;
	logic [NCH-1:0] chanNxt;
	logic [NHO-1:0] hostNxt;
	logic phase_r;
	logic sampleNow;

	// Trip sources merge before the synchroniser: one event, one delay
	assign tripMerged = extSrc.pwmATrip | extSrc.pwmBTrip;
	assign rawIn = {extSrc.suspend, extSrc.uartB, extSrc.uartA,
		tripMerged, extSrc.uartC, extEvents};

	genvar g;
	generate
		for (g = 0; g < NASYNC; g++) begin : gSync
			always_ff @(posedge mclk) begin
				if (reset)
					syncPipe[g] <= '0;
				else
					syncPipe[g] <= {syncPipe[g][SS-2:0], rawIn[g]};
			end
			// A change counts once second and third stage agree
			assign stable[g] = syncPipe[g][SS-1] == syncPipe[g][SS-2];
			always_ff @(posedge mclk) begin
				if (reset)
					cleanIn_r[g] <= 1'b0;
				else if (stable[g])
					cleanIn_r[g] <= syncPipe[g][SS-1];
			end
		end
	endgenerate

	generate
		for (g = 0; g < NPIN; g++) begin : gPin
			always_ff @(posedge mclk) begin
				if (reset)
					pinPipe[g] <= '0;
				else
					pinPipe[g] <= {pinPipe[g][SS-2:0], generalInputPins[g]};
			end
			assign pinStable[g] = pinPipe[g][SS-1] == pinPipe[g][SS-2];
			always_ff @(posedge mclk) begin
				if (reset)
					gpIn_r[g] <= 1'b0;
				else if (pinStable[g])
					gpIn_r[g] <= pinPipe[g][SS-1];
			end
		end
	endgenerate

	// Internal module events share the clock: no synchroniser
	always_comb begin
		modLevel = '0;
		modLevel[`ER_MOD_EVT_LO +: 16] = moduleEvents;
	end

	// Event 32 is shared by an external line and serial port C
	always_comb begin
		extLevel = '0;
		extLevel[`ER_EXT_EVT_LO +: 16] = cleanIn_r[15:0];
		extLevel[`ER_EVT_UART1] = cleanIn_r[16] | cleanIn_r[0];
		extLevel[`ER_EVT_TRIP] = cleanIn_r[17];
		extLevel[`ER_EVT_UART0] = cleanIn_r[18];
		extLevel[`ER_EVT_UART2] = cleanIn_r[19];
		extLevel[`ER_EVT_SUSPEND] = cleanIn_r[20];
	end

	// Core writes may raise only events of their own range
	assign coreSetOk = coreCmd.set &&
		coreCmd.evt >= 6'(`ER_CORE_EVT_LO) &&
		coreCmd.evt < 6'(`ER_EXT_EVT_LO);
	always_comb begin
		coreLevel = '0;
		if (coreSetOk)
			coreLevel[coreCmd.evt] = 1'b1;
	end
	assign evtLevel = modLevel | extLevel | coreLevel;

	always_comb begin
		clrMask = '0;
		if (coreCmd.clr)
			clrMask[coreCmd.evt] = 1'b1;
	end
	// Set wins over a clear in the same cycle, so no event is lost
	assign setNxt = (pending_r & ~clrMask) | evtLevel;
	always_ff @(posedge mclk) begin
		if (reset)
			pending_r <= '0;
		else
			pending_r <= setNxt;
	end

	// Several events may feed one channel; the channel is their OR
	generate
		for (g = 0; g < NCH; g++) begin : gChan
			logic [NEV-1:0] hit;
			always_comb begin
				hit = '0;
				for (int e = 0; e < NEV; e++)
					hit[e] = pending_r[e] && enable[e] &&
						evtToChan[e*4 +: 4] == 4'(g);
			end
			assign chanNxt[g] = |hit;
		end
	endgenerate
	always_ff @(posedge mclk) begin
		if (reset)
			chanActive_r <= '0;
		else
			chanActive_r <= chanNxt;
	end

	// Host numbers at or above the host count match no output
	generate
		for (g = 0; g < NHO; g++) begin : gHost
			logic [NCH-1:0] sel;
			always_comb begin
				sel = '0;
				for (int c = 0; c < NCH; c++)
					sel[c] = chanActive_r[c] &&
						chanToHost[c*4 +: 4] == 4'(g);
			end
			assign hostNxt[g] = |sel;
		end
	endgenerate
	always_ff @(posedge mclk) begin
		if (reset)
			firstCoreHostLines_r <= '0;
		else
			firstCoreHostLines_r <= hostNxt[1:0];
	end
	always_ff @(posedge mclk) begin
		if (reset)
			exportedHosts_r <= '0;
		else
			exportedHosts_r <= hostNxt[NHO-1:2];
	end

	// Mode 0 is direct connect; others sample once per two cycles
	always_ff @(posedge mclk) begin
		if (reset)
			phase_r <= 1'b0;
		else
			phase_r <= ~phase_r;
	end
	assign sampleNow = ioMode == 2'd0 || phase_r;

	// Held at zero until written, so pins never see stale data
	always_ff @(posedge mclk) begin
		if (reset)
			coreGeneralOutput_r <= '0;
		else if (outWrite)
			coreGeneralOutput_r <= outWriteData;
	end
	always_ff @(posedge mclk) begin
		if (reset)
			coreInputEvent_r <= '0;
		else if (sampleNow)
			coreInputEvent_r <= {hostNxt[1:0], gpIn_r[29:0]};
	end
endmodule // subsystem_event_router
`default_nettype wire

/* shared/event_router_map.svh */
`ifndef EVENT_ROUTER_MAP_SVH
`define EVENT_ROUTER_MAP_SVH
`define ER_NUM_EVENTS 64
`define ER_NUM_CHANNELS 16
`define ER_NUM_HOSTS 10
`define ER_CORE_HOSTS 2
`define ER_MOD_EVT_LO 0
`define ER_CORE_EVT_LO 16
`define ER_EXT_EVT_LO 32
`define ER_EVT_UART1 32
`define ER_EVT_UART0 51
`define ER_EVT_UART2 52
`define ER_EVT_TRIP 56
`define ER_EVT_SUSPEND 58
`define ER_SYNC_STAGES 3
`endif

/* shared/event_router_pkg.sv */
package event_router_pkg;
	typedef struct packed {
		logic [5:0] evt;
		logic set;
		logic clr;
	} evt_cmd_t;
	typedef struct packed {
		logic suspend;
		logic uartA;
		logic uartB;
		logic uartC;
		logic pwmATrip;
		logic pwmBTrip;
	} ext_src_t;
endpackage
